// ==== hdl/gic_map.svh ====
`ifndef GIC_MAP_SVH
`define GIC_MAP_SVH

// APB register byte offsets
`define GIC_STATUS_OFS   8'h00
`define GIC_GAIN_OFS     8'h04
`define GIC_SETTLE_OFS   8'h08
`define GIC_STATE_OFS    8'h0c

// Timing, system clock in MHz
`define GIC_CLK_MHZ      100
`define GIC_SETTLE_US    25
`define GIC_SETTLE_CYC   (`GIC_SETTLE_US * `GIC_CLK_MHZ)
`define GIC_SWITCH_US    1
`define GIC_SWITCH_CYC   (`GIC_SWITCH_US * `GIC_CLK_MHZ)
// Pin edge to output flop: two sync stages, state flop, output flop
`define GIC_PATH_CYC     4

// Field layout and widths
`define GIC_CNT_W        16
`define GIC_ADDR_LSB     0
`define GIC_ADDR_MSB     7
`define GIC_VALID_LSB    16
`define GIC_CH_MAX       16

`endif

// ==== hdl/gic_pkg.sv ====
package gic_pkg;

   // Controller lines of one channel, as they arrive on the pins
   typedef struct packed {
      logic       clearN;   // Low forces clearing
      logic       holdSel;  // Low integrates, high holds
      logic [1:0] gainSel;  // Bit 1 is the MSB line
   } gic_pins_type;

   // Switch and status drive of one channel
   typedef struct packed {
      logic       resetSw;     // Closes the integrator reset switch
      logic       integSw;     // Connects the input to the integrator
      logic       monitor;     // Logic monitor output
      logic       resultValid; // Held value has settled
      logic [3:0] scale;       // One-hot: x1, x2, x5, x10
   } gic_drive_type;

   typedef enum logic [1:0] {
      ST_CLEAR,
      ST_INTEG,
      ST_HOLD
   } gic_state_type;

endpackage

// ==== hdl/gic_sync.sv ====
`timescale 1ns/1ps
// Two-stage synchroniser; stage one feeds stage two only
module gic_sync #(
   parameter int W = 4
) (
   input  wire logic         clk,
   input  wire logic         rstn,
   input  wire logic [W-1:0] asyncIn,
   output logic [W-1:0]      syncOut
);

   logic [W-1:0] meta_q;

   // Reset to zero: a cleared line means clearing, the safe state
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         meta_q  <= '0;
         syncOut <= '0;
      end else begin
         meta_q  <= asyncIn;
         syncOut <= meta_q;
      end
   end

endmodule

// ==== hdl/gic_chan_ctrl.sv ====
// The placing of the registers and the APB slave port were left to the implementer.
`timescale 1ns/1ps
`include "gic_map.svh"

//Contract
// - Select low integrates, high holds result.
// - Clear low forces clearing, high enables.
// - Monitor high while clearing or integrating.
// - Hold keeps output constant until change.
// - Boxcar: windows accumulate until clear.
// - Gain code selects 1, 2, 5, 10.
// - Two to sixteen channels, in pairs.
// - Changes complete within 1 us.
module gic_chan_ctrl #(
   parameter int NUM_CH = 2
) (
   input  wire logic                              clk,
   input  wire logic                              rstn,
   // APB slave
   input  wire logic                              psel,
   input  wire logic                              penable,
   input  wire logic                              pwrite,
   input  wire logic [31:0]                       paddr,
   input  wire logic [31:0]                       pwdata,
   input  wire logic [3:0]                        pstrb,
   output logic [31:0]                            prdata,
   output logic                                   pready,
   output logic                                   pslverr,
   // Channel pins and drive
   input  wire gic_pkg::gic_pins_type [NUM_CH-1:0] chPins,
   output gic_pkg::gic_drive_type [NUM_CH-1:0]    chDrive,
   output logic                                   powerInd
);

   localparam int PW = $bits(gic_pkg::gic_pins_type);

   // Elaboration checks on the channel count and switching budget
   generate
      if (NUM_CH < 2 || NUM_CH > `GIC_CH_MAX || (NUM_CH % 2) != 0) begin : g_badCh
         $error("NUM_CH must be even, from 2 to 16");
      end
      if (`GIC_PATH_CYC > `GIC_SWITCH_CYC) begin : g_badPath
         $error("Pin-to-switch path exceeds switching budget");
      end
      if (`GIC_SETTLE_CYC >= (1 << `GIC_CNT_W)) begin : g_badSettle
         $error("Settling count does not fit the counter");
      end
   endgenerate

   logic [NUM_CH*PW-1:0]                  rawPins;
   logic [NUM_CH*PW-1:0]                  syncPins;
   gic_pkg::gic_pins_type [NUM_CH-1:0]    pinS;
   gic_pkg::gic_state_type                state_q [NUM_CH];
   logic [`GIC_CNT_W-1:0]                 cnt_q   [NUM_CH];
   logic [`GIC_CNT_W-1:0]                 settle_q;
   logic [NUM_CH-1:0]                     monVec;
   logic [NUM_CH-1:0]                     validVec;
   logic [2*NUM_CH-1:0]                   gainVec;
   logic [2*NUM_CH-1:0]                   stateVec;
   logic                                  apbAccess;
   logic                                  apbDone;
   logic                                  apbFirst;
   logic                                  apbErr;
   logic [`GIC_ADDR_MSB:`GIC_ADDR_LSB]    regAddr;
   logic                                  addrHit;
   logic                                  addrRo;
   logic [31:0]                           rdMux;

   // All controller lines pass two flops before any logic
   assign rawPins = chPins;
   gic_sync #(
      .W       (NUM_CH*PW)
   ) u_sync (
      .clk     (clk),
      .rstn    (rstn),
      .asyncIn (rawPins),
      .syncOut (syncPins)
   );
   assign pinS = syncPins;

   // Every channel has its own lines, state and drive
   genvar ch;
   generate
      for (ch = 0; ch < NUM_CH; ch++) begin : g_ch

         // Channel sequencer; clear outranks the select line
         always_ff @(posedge clk or negedge rstn) begin
            if (!rstn) begin
               state_q[ch] <= gic_pkg::ST_CLEAR;
            end else if (!pinS[ch].clearN) begin
               state_q[ch] <= gic_pkg::ST_CLEAR;
            end else if (!pinS[ch].holdSel) begin
               // From hold too: boxcar windows add to the held value
               state_q[ch] <= gic_pkg::ST_INTEG;
            end else begin
               state_q[ch] <= gic_pkg::ST_HOLD;
            end
         end

         // Settling counter restarts on every entry into hold
         always_ff @(posedge clk or negedge rstn) begin
            if (!rstn) begin
               cnt_q[ch] <= '0;
            end else if (state_q[ch] != gic_pkg::ST_HOLD) begin
               cnt_q[ch] <= '0;
            end else if (cnt_q[ch] < settle_q) begin
               cnt_q[ch] <= cnt_q[ch] + `GIC_CNT_W'(1);
            end
         end

         // Switch drive, one flop after the state: four cycles in all
         always_ff @(posedge clk or negedge rstn) begin
            if (!rstn) begin
               chDrive[ch] <= '{resetSw: 1'b1, integSw: 1'b0, monitor: 1'b1,
                                resultValid: 1'b0, scale: 4'h1};
            end else begin
               chDrive[ch].resetSw <= (state_q[ch] == gic_pkg::ST_CLEAR);
               // Hold opens both switches, so the output stays put
               chDrive[ch].integSw <= (state_q[ch] == gic_pkg::ST_INTEG);
               chDrive[ch].monitor <= (state_q[ch] != gic_pkg::ST_HOLD);
               chDrive[ch].resultValid <= (state_q[ch] == gic_pkg::ST_HOLD)
                                          && (cnt_q[ch] >= settle_q)
                                          && pinS[ch].clearN && pinS[ch].holdSel;
               case (pinS[ch].gainSel)
                  2'h0:    chDrive[ch].scale <= 4'h1;   // x1
                  2'h1:    chDrive[ch].scale <= 4'h2;   // x2
                  2'h2:    chDrive[ch].scale <= 4'h4;   // x5
                  2'h3:    chDrive[ch].scale <= 4'h8;   // x10
                  default: chDrive[ch].scale <= 4'h1;
               endcase
            end
         end

         assign monVec[ch]          = chDrive[ch].monitor;
         assign validVec[ch]        = chDrive[ch].resultValid;
         assign gainVec[2*ch +: 2]  = pinS[ch].gainSel;
         assign stateVec[2*ch +: 2] = state_q[ch];
      end
   endgenerate

   // Power indicator rises at the first edge after reset
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         powerInd <= 1'b0;
      end else begin
         powerInd <= 1'b1;
      end
   end

   // APB decode; pready comes from a flop, one wait state per access
   assign apbAccess = psel && penable;
   assign apbDone   = apbAccess && pready;
   assign regAddr   = paddr[`GIC_ADDR_MSB:`GIC_ADDR_LSB];
   assign addrHit   = (paddr[31:`GIC_ADDR_MSB+1] == '0) && (paddr[1:0] == 2'h0) &&
                      (regAddr == `GIC_STATUS_OFS || regAddr == `GIC_GAIN_OFS ||
                       regAddr == `GIC_SETTLE_OFS || regAddr == `GIC_STATE_OFS);
   assign addrRo    = (regAddr != `GIC_SETTLE_OFS);

   // First access-phase cycle; the wait state comes from pready itself
   assign apbFirst  = apbAccess && !pready;
   assign apbErr    = !addrHit || (pwrite && addrRo);

   // Read mux; unused upper bits read as zero
   always_comb begin
      rdMux = 32'h0;
      case (regAddr)
         `GIC_STATUS_OFS: begin
            rdMux[NUM_CH-1:0] = monVec;
            rdMux[`GIC_VALID_LSB +: NUM_CH] = validVec;
         end
         `GIC_GAIN_OFS:   rdMux[2*NUM_CH-1:0] = gainVec;
         `GIC_SETTLE_OFS: rdMux[`GIC_CNT_W-1:0] = settle_q;
         `GIC_STATE_OFS:  rdMux[2*NUM_CH-1:0] = stateVec;
         default:         rdMux = 32'h0;
      endcase
   end

   // Ready pulse, one cycle per access
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         pready <= 1'b0;
      end else begin
         pready <= apbFirst;
      end
   end

   // Error flag stands only beside the ready pulse
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         pslverr <= 1'b0;
      end else begin
         pslverr <= apbFirst && apbErr;
      end
   end

   // Read data; zero outside the ready cycle keeps stale values off the bus
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         prdata <= 32'h0;
      end else if (apbFirst && !pwrite && addrHit) begin
         prdata <= rdMux;
      end else begin
         prdata <= 32'h0;
      end
   end

   // Settling count, in clock cycles, programmable by byte lane
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         settle_q <= `GIC_CNT_W'(`GIC_SETTLE_CYC);
      end else if (apbDone && pwrite && regAddr == `GIC_SETTLE_OFS && addrHit) begin
         if (pstrb[0]) begin
            settle_q[7:0] <= pwdata[7:0];
         end
         if (pstrb[1]) begin
            settle_q[15:8] <= pwdata[15:8];
         end
      end
   end

endmodule

// ==== test/gic_chan_ctrl_properties.sv ====
`timescale 1ns/1ps
module gic_chan_ctrl_properties #(
   parameter int NUM_CH = 2
) (
   input wire logic                               clk,
   input wire logic                               rstn,
   input wire logic                               powerInd,
   input wire gic_pkg::gic_pins_type [NUM_CH-1:0]  chPins,
   input wire gic_pkg::gic_drive_type [NUM_CH-1:0] chDrive
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (!rstn);
   // Channel 0 only; the bench compares the others
   wire gic_pkg::gic_drive_type d = chDrive[0];
   wire gic_pkg::gic_pins_type  p = chPins[0];
   chk_mon_state: assert property (d.monitor == (d.resetSw || d.integSw))
      else $error("Monitor disagrees with switch state");
   // Five samples cover two sync stages, state and output flop
   chk_clear_wins: assert property (!p.clearN [*5] |-> d.resetSw && !d.integSw)
      else $error("Clear pin did not force clearing");
   chk_integ_path: assert property ((p.clearN && !p.holdSel) [*5] |-> d.integSw && !d.resetSw)
      else $error("Integrate select not followed");
   chk_hold_steady: assert property ((p.clearN && p.holdSel) [*5] |-> !d.integSw && !d.resetSw && !d.monitor)
      else $error("Hold not kept");
   chk_gain_scale: assert property ($stable(p.gainSel) [*5] |-> d.scale == (4'h1 << p.gainSel))
      else $error("Scale does not match gain code");
   chk_sync_delay: assert property (p.clearN [*5] ##1 !p.clearN |-> !d.resetSw [*3])
      else $error("Clear reacted before two sync stages");
   chk_valid_wait: assert property ($rose(d.resultValid) |-> $past(!d.monitor, 5))
      else $error("Result valid before settling");
   chk_valid_drop: assert property (d.monitor |-> !d.resultValid)
      else $error("Result valid outside hold");
   chk_power_on: assert property ($past(rstn) |-> powerInd)
      else $error("Power indicator low while running");
   cov_valid: cover property ($rose(d.resultValid));
   cov_integ: cover property ($rose(d.integSw));
   cov_top_gain: cover property (d.scale == 4'h8);
endmodule

bind gic_chan_ctrl gic_chan_ctrl_properties #(.NUM_CH(NUM_CH)) gic_props (.clk(clk), .rstn(rstn),
   .powerInd(powerInd), .chPins(chPins), .chDrive(chDrive));

// ==== test/gic_ctrl_model.sv ====
`timescale 1ns/1ps
// Acquisition controller driving two channels' control lines
module gic_ctrl_model #(
   parameter int CLR_CYC    = 2500,
   parameter int SETTLE_CYC = 30
) (
   input  wire logic                   clk,
   output gic_pkg::gic_pins_type [1:0] pins
);
   // Power-up: clearing, holding, gain x1
   initial pins = {2{4'h4}};

   // Minimum dwell applied here, so the bench cannot break it by accident
   task automatic drive(int c, bit clr, bit hold, int n);
      @(posedge clk);
      pins[c].clearN <= clr;
      pins[c].holdSel <= hold | !clr;
      if (!clr && n < CLR_CYC) n = CLR_CYC;
      if (hold && n < SETTLE_CYC) n = SETTLE_CYC;
      repeat (n) @(posedge clk);
   endtask

   task automatic gain(int c, int g);
      @(posedge clk);
      pins[c].gainSel <= g[1:0];
   endtask
endmodule

// ==== test/testbench.sv ====
`timescale 1ns/1ps
module testbench;
   logic                        clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [31:0]                 paddr = 0, pwdata = 0, prdata, rd;
   logic [3:0]                  pstrb = 4'hf;
   logic                        pready, pslverr, powerInd;
   gic_pkg::gic_pins_type [1:0]  chPins;
   gic_pkg::gic_drive_type [1:0] chDrive;
   int                          bad_count = 0, checks_done = 0, expSt[2], expGain[2];

   always #5 clk = ~clk;

   gic_chan_ctrl #(.NUM_CH(2)) gic_chan_ctrl_inst (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .chPins(chPins), .chDrive(chDrive), .powerInd(powerInd));
   gic_ctrl_model gic_ctrl_model_inst (.clk(clk), .pins(chPins));

   task automatic conclude;
      $display("Checks %0d, errors %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   task automatic cmp(logic [31:0] got, logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         bad_count++;
         $display("Error at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask

   // One APB transfer; entered just after a rising edge
   task automatic apb(logic wr, logic [7:0] a, logic [31:0] dat, logic err);
      int n;
      psel <= 1;
      pwrite <= wr;
      paddr <= {24'h0, a};
      pwdata <= dat;
      @(posedge clk);
      penable <= 1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         bad_count++;
         $display("Error at %0t: bus answer timed out", $time);
         conclude;
      end
      cmp(pslverr, err);
      rd = prdata;
      psel <= 0;
      penable <= 0;
      @(posedge clk);
   endtask

   // Expected drive worked out from the pin levels alone
   task automatic chk(int c);
      gic_pkg::gic_drive_type e;
      repeat (6) @(posedge clk);
      e.resetSw = expSt[c] == 0;
      e.integSw = expSt[c] == 1;
      e.monitor = expSt[c] != 2;
      e.resultValid = expSt[c] == 2;
      e.scale = 4'h1 << expGain[c];
      cmp(chDrive[c], e);
      apb(0, 8'h0c, 0, 0);
      cmp(rd[2*c+:2], expSt[c]);
      apb(0, 8'h00, 0, 0);
      cmp(rd[c], e.monitor);
      cmp(rd[16+c], e.resultValid);
   endtask

   task automatic act(int c, bit clr, bit hold, int n);
      gic_ctrl_model_inst.drive(c, clr, hold, n);
      expSt[c] = !clr ? 0 : (hold ? 2 : 1);
      chk(c);
   endtask

   task automatic gset(int c, int g);
      gic_ctrl_model_inst.gain(c, g);
      expGain[c] = g;
      chk(c);
      apb(0, 8'h04, 0, 0);
      cmp(rd[2*c+:2], g);
   endtask

   initial begin
      #1000000;
      bad_count++;
      $display("Error at %0t: run timed out", $time);
      conclude;
   end

   initial begin
      void'($urandom(87));
      repeat (10) @(posedge clk);
      cmp(chDrive, 16'ha1a1);
      cmp(powerInd, 0);
      repeat (10) @(posedge clk);
      rstn <= 1;
      repeat (2) @(posedge clk);
      cmp(powerInd, 1);
      // Reset count: 25 us at 100 MHz
      apb(0, 8'h08, 0, 0);
      cmp(rd, 32'h0000_09c4);
      // Low lane only: the upper byte keeps its reset value
      pstrb <= 4'h1;
      apb(1, 8'h08, 32'h0000_7705, 0);
      pstrb <= 4'hf;
      apb(0, 8'h08, 0, 0);
      cmp(rd, 32'h0000_0905);
      // Short settle count keeps the run brief
      apb(1, 8'h08, 5, 0);
      apb(0, 8'h08, 0, 0);
      cmp(rd, 5);
      apb(1, 8'h00, 1, 1);
      apb(0, 8'h10, 0, 1);
      cmp(rd, 0);
      for (int c = 0; c < 2; c++) begin
         act(c, 0, 1, 0);
         act(c, 1, 1, 0);
         for (int g = 0; g < 4; g++) gset(c, g);
         // Boxcar: windows back to back with no clear between
         repeat (3) begin
            act(c, 1, 0, 1 + $urandom_range(40));
            act(c, 1, 1, 0);
            gset(c, $urandom_range(3));
         end
         act(c, 0, 1, 0);
      end
      conclude;
   end
endmodule
